//--- design/ssh_map.vh
/*
 Constants for the serial management slave: addresses, opcodes, buffer layout,
 extended command codes, timing counts and configuration reset values.
 Assumes a 20 MHz system clock.
*/
`ifndef SSH_MAP_VH
`define SSH_MAP_VH
`define SSH_CLK_MHZ 20
`define SSH_ADDR_LOW 7'h2c
`define SSH_ADDR_HIGH 7'h2d
`define SSH_OP_REBOOT 16'h9936
`define SSH_OP_CFG_ACCESS 16'h9937
`define SSH_OP_EXT_CMD 16'h993e
`define SSH_OP_ATTACH 16'haa55
`define SSH_OP_ATTACH_SMB 16'haa56
`define SSH_OP_TERM 8'h00
`define SSH_REG_EXT_COMMAND_CODE 16'h0000
`define SSH_REG_EXT_COMMAND_RESULT 16'h0001
`define SSH_REG_EXT_FIRST_DATA_BYTE 16'h0002
`define SSH_BLOCK_MAX 8'h20
`define SSH_RAM_DEPTH 64
`define SSH_RAM_AW 6
`define SSH_EXT_SET_ADDR 8'h00
`define SSH_EXT_GET_DEF_ADDR 8'h01
`define SSH_EXT_HUB_INFO 8'h02
`define SSH_EXT_CHG_MASK 8'h03
`define SSH_EXT_PORT_CONNECT 8'h80
`define SSH_EXT_PORT_POWER 8'h81
`define SSH_EXT_PORT_DISABLE 8'h82
`define SSH_EXT_PORT_DPDM 8'h83
`define SSH_EXT_CHG_FIRST 8'h84
`define SSH_EXT_CHG_LAST 8'h87
`define SSH_STAT_OK 8'h01
`define SSH_STAT_BAD 8'h02
`define SSH_PWR_STEP_MS 2
`define SSH_PWR_STEP_CYC (`SSH_PWR_STEP_MS * 1000 * `SSH_CLK_MHZ)
`define SSH_OC2_T0_NS 50
`define SSH_OC2_T1_NS 200
`define SSH_OC2_T2_NS 400
`define SSH_OC2_T3_NS 1000
`define SSH_OC3_T0_NS 750
`define SSH_OC3_T1_NS 1250
`define SSH_OC3_T2_NS 1500
`define SSH_OC3_T3_NS 10000
`define SSH_NS_TO_CYC(t) (((t) * `SSH_CLK_MHZ + 999) / 1000)
`define SSH_RST_PWR_ON 8'h32
`define SSH_RST_OC_SEL 2'h0
`define SSH_RST_SWAP 5'h00
`define SSH_PORTS 5
`endif

//--- design/ssh_smbus_slave.v
/*
 Serial management slave of a hub controller: buffer access, special opcodes,
 extended commands and the configuration settings they steer.
 Assumes the bus pins arrive asynchronously; the data pin is open drain.
*/
// Contract
// - Accesses carry 7-bit address, 16-bit buffer offset, then 8-bit data bytes.
// - Slave answers at one of two strap-selected 7-bit addresses.
// - Bytes shift most significant bit first in both directions.
// - Count is never zero; at most 32 data bytes per block.
// - Block read uses repeated start then read address to turn direction.
// - Special opcode replaces offset and ends with a zero byte (here 9937h instead takes a count byte, then register bytes).
// - Opcode 9936h reboots the controller; 9937h accesses configuration registers.
// - Opcode 993Eh runs the extended command held in the buffer.
// - AA55h attaches and ends configuration; AA56h keeps bus access too.
// - Codes 00h-03h: set address, default address, hub info, charger mask.
// - Codes 80h-83h port status/disable; 84h-87h charger controller transfers (here only answered with OK status, no transfer).
// - Command code at 0000h, status at 0001h, data from 0002h.
// - Host zeroes status first; device writes result status afterwards.
// - Power-on-to-good delay counted in 2 ms steps for both hubs.
// - USB 2.0 over-current filter 50/200/400/1000 ns; shorter pulses ignored.
// - USB 3.0 over-current filter 750/1250/1500/10000 ns; shorter pulses ignored.
// - Per-port data line swap; index zero is upstream, higher are downstream.
// - Hub-wide setting forbids USB 2.0 high speed.
// - Hub-wide setting turns off multiple translator operation.
// - Setting suppresses end-of-packet at first frame end point in full speed.
// - Set-address command takes new bus address from first data byte.
// - Per-port commands use first data byte as mask, bit zero upstream.
`include "ssh_map.vh"
`timescale 1ns/100ps
`default_nettype none
module ssh_smbus_slave #(
	parameter PWR_STEP_CYC = `SSH_PWR_STEP_CYC
) (
	input wire i_clk,
	input wire i_reset,
	input wire i_scl,
	input wire i_sda,
	output wire o_sda,
	output wire o_sda_oe,
	input wire i_addr_strap,
	input wire [4:0] i_port_connect,
	input wire [4:0] i_port_power,
	input wire i_oc2_n,
	input wire i_oc3_n,
	output reg o_reboot,
	output reg o_attach,
	output reg o_smbus_keep,
	output reg o_power_good,
	output reg o_oc2,
	output reg o_oc3,
	output reg [4:0] o_dpdm_swap,
	output reg o_hs_disable,
	output reg o_multi_translator_disable,
	output reg o_eop_first_frame_end_disable,
	output reg o_power_switch_select,
	output reg [4:0] o_port_force_off
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_OFFH = 3'h2;
	localparam ST_OFFL = 3'h3;
	localparam ST_WDATA = 3'h4;
	localparam ST_RDATA = 3'h5;
	localparam ST_SKIP = 3'h6;
	// Configuration register indices reached through opcode 9937h
	localparam CFG_PWR_ON = 6'h00;
	localparam CFG_OC_SEL = 6'h01;
	localparam CFG_SWAP = 6'h02;
	localparam CFG_ADV = 6'h03;

	reg [1:0] scl_s, sda_s;
	reg [1:0] strap_s;
	wire scl = scl_s[1];
	wire sda = sda_s[1];
	reg scl_d, sda_d;
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_c = scl & scl_d & sda_d & ~sda;
	wire stop_c = scl & scl_d & ~sda_d & sda;

	reg [7:0] ram [0:`SSH_RAM_DEPTH-1];
	reg [2:0] state;
	reg [3:0] bitc;
	reg [7:0] sh;
	reg ack_drive, rd_drive, rd_bit;
	reg [15:0] offset;
	reg [7:0] opc_hi;
	reg is_op;
	reg [6:0] my_addr;
	reg [1:0] addr_init;
	reg [7:0] count;
	reg got_count;
	reg [7:0] cfg_idx;
	reg op_pend;
	reg [15:0] opcode;
	reg ext_busy;
	reg [7:0] pwr_on;
	reg [3:0] oc_sel;
	reg [2:0] adv;
	reg [31:0] pwr_cnt;
	reg [7:0] pwr_steps;
	reg [9:0] oc2_cnt, oc3_cnt;
	reg [1:0] oc2_s, oc3_s;
	integer k;

	function [9:0] oc_limit;
		input is3;
		input [1:0] sel;
		integer t;
		begin
			case ({is3, sel})
			3'h0: t = `SSH_NS_TO_CYC(`SSH_OC2_T0_NS);
			3'h1: t = `SSH_NS_TO_CYC(`SSH_OC2_T1_NS);
			3'h2: t = `SSH_NS_TO_CYC(`SSH_OC2_T2_NS);
			3'h3: t = `SSH_NS_TO_CYC(`SSH_OC2_T3_NS);
			3'h4: t = `SSH_NS_TO_CYC(`SSH_OC3_T0_NS);
			3'h5: t = `SSH_NS_TO_CYC(`SSH_OC3_T1_NS);
			3'h6: t = `SSH_NS_TO_CYC(`SSH_OC3_T2_NS);
			default: t = `SSH_NS_TO_CYC(`SSH_OC3_T3_NS);
			endcase
			oc_limit = t[9:0];
		end
	endfunction

	assign o_sda = 1'b0;
	assign o_sda_oe = ack_drive | (rd_drive & ~rd_bit);

	wire [`SSH_RAM_AW-1:0] ram_a = offset[`SSH_RAM_AW-1:0];
	wire [7:0] cmd_code = ram[0];

	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			strap_s <= 2'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			oc2_s <= 2'h3;
			oc3_s <= 2'h3;
		end else begin
			scl_s <= {scl_s[0], i_scl};
			sda_s <= {sda_s[0], i_sda};
			strap_s <= {strap_s[0], i_addr_strap};
			scl_d <= scl;
			sda_d <= sda;
			oc2_s <= {oc2_s[0], i_oc2_n};
			oc3_s <= {oc3_s[0], i_oc3_n};
		end
	end

	// Protocol engine
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= ST_IDLE;
			bitc <= 4'h0;
			sh <= 8'h00;
			ack_drive <= 1'b0;
			rd_drive <= 1'b0;
			rd_bit <= 1'b1;
			offset <= 16'h0000;
			opc_hi <= 8'h00;
			is_op <= 1'b0;
			my_addr <= 7'h00;
			addr_init <= 2'h0;
			count <= 8'h00;
			got_count <= 1'b0;
			cfg_idx <= 8'h00;
			op_pend <= 1'b0;
			opcode <= 16'h0000;
			ext_busy <= 1'b0;
			o_reboot <= 1'b0;
			o_attach <= 1'b0;
			o_smbus_keep <= 1'b0;
			pwr_on <= `SSH_RST_PWR_ON;
			oc_sel <= 4'h0;
			o_dpdm_swap <= `SSH_RST_SWAP;
			adv <= 3'h0;
			o_power_switch_select <= 1'b0;
			o_port_force_off <= 5'h00;
			for (k = 0; k < `SSH_RAM_DEPTH; k = k + 1)
				ram[k] <= 8'h00;
		end else begin
			o_reboot <= 1'b0;
			// Strap settles through its synchroniser before the third edge
			if (addr_init != 2'h3) begin
				addr_init <= addr_init + 2'h1;
				my_addr <= strap_s[1] ? `SSH_ADDR_HIGH : `SSH_ADDR_LOW;
			end
			if (start_c) begin
				state <= ST_ADDR;
				bitc <= 4'h0;
				ack_drive <= 1'b0;
				rd_drive <= 1'b0;
			end else if (stop_c) begin
				state <= ST_IDLE;
				ack_drive <= 1'b0;
				rd_drive <= 1'b0;
				if (op_pend) begin
					op_pend <= 1'b0;
					case (opcode)
					`SSH_OP_REBOOT: o_reboot <= 1'b1;
					`SSH_OP_ATTACH: o_attach <= 1'b1;
					`SSH_OP_ATTACH_SMB: begin
						o_attach <= 1'b1;
						o_smbus_keep <= 1'b1;
					end
					`SSH_OP_EXT_CMD: ext_busy <= 1'b1;
					default: ;
					endcase
				end
			end else if (scl_rise && state != ST_IDLE && state != ST_SKIP && bitc < 4'h8) begin
				if (state != ST_RDATA)
					sh <= {sh[6:0], sda};
				bitc <= bitc + 4'h1;
			end else if (scl_fall && state != ST_IDLE && state != ST_SKIP) begin
				if (bitc == 4'h8) begin
					bitc <= 4'h9;
					ack_drive <= 1'b0;
					rd_drive <= 1'b0;
					case (state)
					ST_ADDR: begin
						if (sh[7:1] == my_addr) begin
							ack_drive <= 1'b1;
							if (sh[0])
								state <= ST_RDATA;
							else begin
								state <= ST_OFFH;
								got_count <= 1'b0;
								is_op <= 1'b0;
							end
						end else
							state <= ST_SKIP;
					end
					ST_OFFH: begin
						opc_hi <= sh;
						ack_drive <= 1'b1;
						state <= ST_OFFL;
					end
					ST_OFFL: begin
						ack_drive <= 1'b1;
						offset <= {opc_hi, sh};
						opcode <= {opc_hi, sh};
						is_op <= (opc_hi == 8'h99 || opc_hi == 8'haa);
						state <= ST_WDATA;
					end
					ST_WDATA: begin
						ack_drive <= 1'b1;
						if (is_op) begin
							if (sh == `SSH_OP_TERM && opcode != `SSH_OP_CFG_ACCESS)
								op_pend <= 1'b1;
							else if (opcode == `SSH_OP_CFG_ACCESS) begin
								if (!got_count) begin
									got_count <= 1'b1;
									op_pend <= 1'b1;
									cfg_idx <= 8'h00;
								end else begin
									cfg_idx <= cfg_idx + 8'h1;
									case (cfg_idx[5:0])
									CFG_PWR_ON: pwr_on <= sh;
									CFG_OC_SEL: oc_sel <= sh[3:0];
									CFG_SWAP: o_dpdm_swap <= sh[4:0];
									CFG_ADV: begin
										adv <= sh[2:0];
										o_power_switch_select <= sh[7];
									end
									default: ;
									endcase
								end
							end
						end else if (!got_count) begin
							got_count <= 1'b1;
							count <= (sh == 8'h00 || sh > `SSH_BLOCK_MAX) ? 8'h00 : sh;
							if (sh == 8'h00 || sh > `SSH_BLOCK_MAX)
								ack_drive <= 1'b0;
						end else if (count != 8'h00) begin
							count <= count - 8'h1;
							ram[ram_a] <= sh;
							offset <= offset + 16'h1;
						end else
							ack_drive <= 1'b0;
					end
					default: rd_drive <= 1'b0;
					endcase
				end else if (bitc == 4'h9) begin
					ack_drive <= 1'b0;
					bitc <= 4'h0;
					// Host acknowledge stands on the data line until this fall
					if (state == ST_RDATA && sda)
						state <= ST_SKIP;
					else if (state == ST_RDATA) begin
						sh <= ram[ram_a];
						offset <= offset + 16'h1;
						rd_drive <= 1'b1;
						rd_bit <= ram[ram_a][7];
					end
				end else if (state == ST_RDATA && rd_drive) begin
					rd_bit <= sh[3'h7 - bitc[2:0]];
				end
			end
			if (ext_busy) begin
				ext_busy <= 1'b0;
				ram[1] <= `SSH_STAT_OK;
				case (cmd_code)
				`SSH_EXT_SET_ADDR: begin
					my_addr <= ram[2][7] ? (strap_s[1] ? `SSH_ADDR_HIGH : `SSH_ADDR_LOW)
						: ram[2][6:0];
				end
				`SSH_EXT_GET_DEF_ADDR: ram[2] <= {1'b0, `SSH_ADDR_HIGH};
				`SSH_EXT_HUB_INFO: ram[2] <= {o_attach, 7'h00};
				`SSH_EXT_CHG_MASK: ram[2] <= 8'h00;
				`SSH_EXT_PORT_CONNECT, `SSH_EXT_PORT_POWER, `SSH_EXT_PORT_DPDM: begin
					for (k = 0; k < `SSH_PORTS; k = k + 1)
						if (ram[2][k])
							ram[3 + k] <= (cmd_code == `SSH_EXT_PORT_POWER) ?
								{7'h00, i_port_power[k]} :
								(cmd_code == `SSH_EXT_PORT_DPDM) ?
								{7'h00, o_dpdm_swap[k]} :
								{6'h00, i_port_connect[k], 1'b0};
				end
				`SSH_EXT_PORT_DISABLE: begin
					for (k = 0; k < `SSH_PORTS; k = k + 1)
						if (ram[2][k] && ram[3 + k][7])
							o_port_force_off[k] <= ram[3 + k][2];
				end
				default: begin
					if (cmd_code < `SSH_EXT_CHG_FIRST || cmd_code > `SSH_EXT_CHG_LAST)
						ram[1] <= `SSH_STAT_BAD;
				end
				endcase
			end
		end
	end

	always @* begin
		o_hs_disable = adv[0];
		o_multi_translator_disable = adv[1];
		o_eop_first_frame_end_disable = adv[2];
	end

	// Power-on to power-good timer in 2 ms steps
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pwr_cnt <= 32'h0;
			pwr_steps <= 8'h00;
			o_power_good <= 1'b0;
		end else if (!o_attach) begin
			pwr_cnt <= 32'h0;
			pwr_steps <= 8'h00;
			o_power_good <= 1'b0;
		end else if (pwr_steps >= pwr_on) begin
			o_power_good <= 1'b1;
		end else if (pwr_cnt >= PWR_STEP_CYC - 1) begin
			pwr_cnt <= 32'h0;
			pwr_steps <= pwr_steps + 8'h1;
		end else
			pwr_cnt <= pwr_cnt + 32'h1;
	end

	// Over-current filters: assert only after the input stays low for the window
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			oc2_cnt <= 10'h0;
			oc3_cnt <= 10'h0;
			o_oc2 <= 1'b0;
			o_oc3 <= 1'b0;
		end else begin
			if (oc2_s[1]) begin
				oc2_cnt <= 10'h0;
				o_oc2 <= 1'b0;
			end else if (oc2_cnt >= oc_limit(1'b0, oc_sel[1:0]))
				o_oc2 <= 1'b1;
			else
				oc2_cnt <= oc2_cnt + 10'h1;
			if (oc3_s[1]) begin
				oc3_cnt <= 10'h0;
				o_oc3 <= 1'b0;
			end else if (oc3_cnt >= oc_limit(1'b1, oc_sel[3:2]))
				o_oc3 <= 1'b1;
			else
				oc3_cnt <= oc3_cnt + 10'h1;
		end
	end
endmodule
`default_nettype wire

//--- test/ssh_host.sv
/*
 Bus host model: drives the clock line and pulls the data line low.
 Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module ssh_host #(parameter int Q = 8) (
	input wire logic i_clk,
	input wire logic i_sda,
	output var logic o_scl,
	output var logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick();
		repeat (Q) @(negedge i_clk);
	endtask
	// Also serves as repeated start
	task automatic start();
		o_sda_low = 1'b0;
		tick();
		o_scl = 1'b1;
		tick();
		o_sda_low = 1'b1;
		tick();
		o_scl = 1'b0;
	endtask
	task automatic stop();
		o_sda_low = 1'b1;
		tick();
		o_scl = 1'b1;
		tick();
		o_sda_low = 1'b0;
		tick();
	endtask
	task automatic bit_io(input logic b, output logic r);
		o_sda_low = !b;
		tick();
		o_scl = 1'b1;
		tick();
		r = i_sda;
		tick();
		o_scl = 1'b0;
		tick();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule
`default_nettype wire

//--- test/ssh_smbus_slave_asserts.sv
/*
 Port checker for the serial management slave.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ssh_smbus_slave_asserts #(parameter PWR_STEP_CYC = 40000) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_oc3_n,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic o_reboot,
	input wire logic o_attach,
	input wire logic o_smbus_keep,
	input wire logic o_power_good,
	input wire logic o_oc3
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	int att_cyc;
	// Cycles since attach rose
	always @(posedge i_clk or posedge i_reset) begin
		if (i_reset || !o_attach) att_cyc <= 0;
		else if (att_cyc < 1000000) att_cyc <= att_cyc + 1;
	end
	sequence s_idle; i_scl && i_sda; endsequence
	sequence s_quiet; !o_sda_oe [*3]; endsequence
	property p_sda_zero; o_sda == 1'b0; endproperty
	property p_oe_scl_low; $changed(o_sda_oe) |-> !i_scl; endproperty
	property p_quiet_reset; $fell(i_reset) |-> s_quiet; endproperty
	property p_reboot_pulse; $rose(o_reboot) |=> !o_reboot; endproperty
	property p_reboot_idle; o_reboot |-> s_idle; endproperty
	property p_attach_hold; o_attach && !o_reboot |=> o_attach; endproperty
	property p_keep_attach; o_smbus_keep |-> o_attach; endproperty
	property p_pg_delay; $rose(o_power_good) |-> att_cyc >= PWR_STEP_CYC; endproperty
	property p_pg_attach; !o_attach |-> !o_power_good; endproperty
	property p_oc3_filter;
		$rose(o_oc3) |-> $past(i_oc3_n, 6) == 1'b0 && $past(i_oc3_n, 12) == 1'b0;
	endproperty
	a_sda_zero: assert property (p_sda_zero) else $error("data driven high");
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved in clock high");
	a_quiet_reset: assert property (p_quiet_reset) else $error("data low after reset");
	a_reboot_pulse: assert property (p_reboot_pulse) else $error("reboot too long");
	a_reboot_idle: assert property (p_reboot_idle) else $error("reboot before stop");
	a_attach_hold: assert property (p_attach_hold) else $error("attach dropped");
	a_keep_attach: assert property (p_keep_attach) else $error("keep without attach");
	a_pg_delay: assert property (p_pg_delay) else $error("power good early");
	a_pg_attach: assert property (p_pg_attach) else $error("power good unattached");
	a_oc3_filter: assert property (p_oc3_filter) else $error("short pulse passed");
endmodule
`default_nettype wire

//--- test/ssh_smbus_slave_tb.sv
/*
 Bench for the serial management slave: transfers, opcodes, settings, filters.
 Assumes the host model and checker are compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
module ssh_smbus_slave_tb;
	localparam logic [6:0] A0 = 7'h2c;
	localparam logic [6:0] A1 = 7'h2a;
	localparam int STEP = 4;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_oc2_n = 1'b1;
	logic i_oc3_n = 1'b1;
	logic strap = 1'b0;
	int n_mismatch = 0;
	int checks_done = 0;
	int n_reboot = 0;
	int pg_wait = 0;
	wire logic scl, sda_low, sda, o_sda, o_sda_oe, o_reboot, o_attach, o_smbus_keep;
	wire logic o_power_good, o_oc2, o_oc3, o_hs_disable, o_multi_translator_disable;
	wire logic o_eop_first_frame_end_disable, o_power_switch_select;
	wire logic [4:0] o_dpdm_swap, o_port_force_off;
	assign sda = (o_sda_oe ? o_sda : 1'b1) & !sda_low;
	ssh_host #(.Q(4)) host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	ssh_smbus_slave #(.PWR_STEP_CYC(STEP)) dut (.i_clk(i_clk), .i_reset(i_reset),
		.i_scl(scl), .i_sda(sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
		.i_addr_strap(strap), .i_port_connect(5'h05), .i_port_power(5'h1f),
		.i_oc2_n(i_oc2_n), .i_oc3_n(i_oc3_n), .o_reboot(o_reboot), .o_attach(o_attach),
		.o_smbus_keep(o_smbus_keep), .o_power_good(o_power_good), .o_oc2(o_oc2),
		.o_oc3(o_oc3), .o_dpdm_swap(o_dpdm_swap), .o_hs_disable(o_hs_disable),
		.o_multi_translator_disable(o_multi_translator_disable),
		.o_eop_first_frame_end_disable(o_eop_first_frame_end_disable),
		.o_power_switch_select(o_power_switch_select), .o_port_force_off(o_port_force_off));
	initial begin
		forever #25 i_clk = !i_clk;
	end
	always @(posedge i_clk) begin
		if (o_reboot === 1'b1) n_reboot++;
		if (o_attach === 1'b1 && o_power_good !== 1'b1) pg_wait++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] off, input logic [7:0] n,
		input logic [31:0] d, output logic aa, output logic ac);
		logic k;
		host.start();
		host.wbyte({a, 1'b0}, aa);
		host.wbyte(off[15:8], k);
		host.wbyte(off[7:0], k);
		host.wbyte(n, ac);
		for (int i = 0; i < n && i < 4; i++) host.wbyte(d[31-8*i -: 8], k);
		host.stop();
		repeat (4) @(negedge i_clk);
	endtask
	task automatic rd(input logic [6:0] a, input logic [15:0] off, input int n,
		output logic [31:0] d);
		logic k;
		logic [7:0] b;
		d = 32'h0;
		host.start();
		host.wbyte({a, 1'b0}, k);
		host.wbyte(off[15:8], k);
		host.wbyte(off[7:0], k);
		host.start();
		host.wbyte({a, 1'b1}, k);
		for (int i = 1; i <= n; i++) begin
			host.rbyte(i == n, b);
			d = {d[23:0], b};
		end
		host.stop();
	endtask
	// Extended command: buffer bytes 0..3, run it, read status and what follows
	task automatic ext(input logic [6:0] a, input logic [31:0] d, input int n,
		output logic [31:0] r);
		logic aa, ac;
		wr(a, 16'h0000, 8'h04, d, aa, ac);
		wr(a, 16'h993e, 8'h00, 32'h0, aa, ac);
		rd(a, 16'h0001, n, r);
	endtask
	task automatic pulse(input logic u3, input int n, output logic seen);
		seen = 1'b0;
		if (u3) i_oc3_n = 1'b0;
		else i_oc2_n = 1'b0;
		for (int i = 0; i < n + 4; i++) begin
			@(negedge i_clk);
			if (i == n) {i_oc2_n, i_oc3_n} = 2'b11;
			seen = seen | (u3 ? o_oc3 : o_oc2);
		end
	endtask
	initial begin
		logic aa, ac, s;
		logic [31:0] r;
		repeat (16) @(negedge i_clk);
		i_reset = 1'b0;
		repeat (4) @(negedge i_clk);
		wr(A0, 16'h0000, 8'h03, 32'h80001f00, aa, ac);
		check(aa, 1'b1);
		check(ac, 1'b1);
		wr(A0, 16'h0000, 8'h21, 32'h11223344, aa, ac);
		check(ac, 1'b0);
		rd(A0, 16'h0000, 3, r);
		check(r, 32'h0080001f);
		wr(A0, 16'h0000, 8'h00, 32'h0, aa, ac);
		check(ac, 1'b0);
		wr(7'h2d, 16'h0000, 8'h01, 32'h0, aa, ac);
		check(aa, 1'b0);
		wr(A0, 16'h993e, 8'h00, 32'h0, aa, ac);
		rd(A0, 16'h0001, 1, r);
		check(r, 32'h01);
		rd(A0, 16'h0003, 4, r);
		check(r, 32'h02000200);
		wr(A0, 16'h0000, 8'h02, 32'h55000000, aa, ac);
		wr(A0, 16'h993e, 8'h00, 32'h0, aa, ac);
		rd(A0, 16'h0001, 1, r);
		check(r, 32'h02);
		wr(A0, 16'h0000, 8'h03, {16'h0000, 1'b0, A1, 8'h00}, aa, ac);
		wr(A0, 16'h993e, 8'h00, 32'h0, aa, ac);
		rd(A1, 16'h0001, 1, r);
		check(r, 32'h01);
		wr(A0, 16'h0000, 8'h01, 32'h0, aa, ac);
		check(aa, 1'b0);
		ext(A1, 32'h81001f00, 4, r);
		check(r, 32'h011f0101);
		ext(A1, 32'h01000000, 3, r);
		check(r, 32'h00012d00);
		ext(A1, 32'h03000000, 2, r);
		check(r, 32'h00000100);
		ext(A1, 32'h82000184, 1, r);
		check({r[7:0], 3'h0, o_port_force_off}, 16'h0101);
		wr(A1, 16'h9937, 8'h04, 32'h02031587, aa, ac);
		check({o_dpdm_swap, o_hs_disable, o_multi_translator_disable}, 7'h57);
		check({o_eop_first_frame_end_disable, o_power_switch_select}, 2'h3);
		ext(A1, 32'h83001f00, 4, r);
		check(r, 32'h011f0100);
		pulse(1'b0, 10, s);
		check(s, 1'b0);
		pulse(1'b0, 30, s);
		check(s, 1'b1);
		pulse(1'b1, 8, s);
		check(s, 1'b0);
		pulse(1'b1, 25, s);
		check(s, 1'b1);
		wr(A1, 16'h9937, 8'h02, 32'h020d0000, aa, ac);
		pulse(1'b0, 2, s);
		check(s, 1'b0);
		pulse(1'b0, 8, s);
		check(s, 1'b1);
		pulse(1'b1, 150, s);
		check(s, 1'b0);
		pulse(1'b1, 220, s);
		check(s, 1'b1);
		wr(A1, 16'haa56, 8'h00, 32'h0, aa, ac);
		repeat (8) @(negedge i_clk);
		check({o_attach, o_smbus_keep, o_power_good}, 3'h7);
		check(pg_wait >= 2 * STEP && pg_wait <= 2 * STEP + 1, 1'b1);
		ext(A1, 32'h02000000, 2, r);
		check(r, 32'h00000180);
		wr(A1, 16'h9936, 8'h00, 32'h0, aa, ac);
		check(aa, 1'b1);
		check(n_reboot, 1);
		strap = 1'b1;
		i_reset = 1'b1;
		repeat (2) @(negedge i_clk);
		i_reset = 1'b0;
		check({o_attach, o_smbus_keep, o_power_good, o_port_force_off}, 8'h00);
		repeat (4) @(negedge i_clk);
		wr(7'h2d, 16'h0000, 8'h01, 32'h0, aa, ac);
		check(aa, 1'b1);
		wr(A0, 16'h0000, 8'h01, 32'h0, aa, ac);
		check(aa, 1'b0);
		give_verdict();
	end
	initial begin
		repeat (80000) @(posedge i_clk);
		n_mismatch++;
		give_verdict();
	end
endmodule
bind ssh_smbus_slave ssh_smbus_slave_asserts #(.PWR_STEP_CYC(PWR_STEP_CYC)) chk (
	.i_clk(i_clk), .i_reset(i_reset), .i_scl(i_scl), .i_sda(i_sda), .i_oc3_n(i_oc3_n),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_reboot(o_reboot), .o_attach(o_attach),
	.o_smbus_keep(o_smbus_keep), .o_power_good(o_power_good), .o_oc3(o_oc3));
`default_nettype wire
